/* File: rtl/pqss_consts.vh */
// constants shared by the phase-key / quadrature-amplitude symbol sequencer
`ifndef PQSS_CONSTS_VH
`define PQSS_CONSTS_VH

// ----------------------------------------------------------------------------
// clock and baud
// ----------------------------------------------------------------------------
`define PQSS_CLK_HZ          32'd200000000
`define PQSS_BAUD_MIN_HZ     32'd100000
`define PQSS_BAUD_MAX_HZ     32'd250000000
`define PQSS_BAUD_DEFAULT_HZ 32'd10000

// ----------------------------------------------------------------------------
// marker index and carrier gate
// ----------------------------------------------------------------------------
`define PQSS_MARKER_MIN      14'd1
`define PQSS_MARKER_MAX      14'd10000
`define PQSS_MARKER_DEFAULT  14'd1
`define PQSS_CARRIER_DEFAULT 1'b1

// ----------------------------------------------------------------------------
// phase-key type codes
// ----------------------------------------------------------------------------
`define PQSS_PSK_BASIC 3'h0
`define PQSS_PSK_BPSK  3'h1
`define PQSS_PSK_QPSK  3'h2
`define PQSS_PSK_OQPSK 3'h3
`define PQSS_PSK_DQPSK 3'h4
`define PQSS_PSK_8     3'h5
`define PQSS_PSK_16    3'h6
`define PQSS_PSK_USER  3'h7

// ----------------------------------------------------------------------------
// quadrature-amplitude type codes and symbol widths
// ----------------------------------------------------------------------------
`define PQSS_QAM_16   2'h0
`define PQSS_QAM_64   2'h1
`define PQSS_QAM_256  2'h2
`define PQSS_QAM_USER 2'h3
`define PQSS_QAM_DEFAULT 2'h0
`define PQSS_QAM16_BITS  4'h4
`define PQSS_QAM64_BITS  4'h6
`define PQSS_QAM256_BITS 4'h8

// ----------------------------------------------------------------------------
// data table characters and user phase limit (hundredths of a degree)
// ----------------------------------------------------------------------------
`define PQSS_CHAR_ZERO     8'h30
`define PQSS_CHAR_ONE      8'h31
`define PQSS_USER_PHASE_MAX 16'h8CA0

`endif

/* File: rtl/pqss_baud_gen.v */
// baud generator: phase accumulator that pulses once per baud interval
`timescale 1ns/1ps
`default_nettype none
`include "pqss_consts.vh"

module pqss_baud_gen
(
    input  wire        clock,
    input  wire        arst_n,
    input  wire        clk_en,
    input  wire        run,
    input  wire [31:0] rate_hz,
    output reg         tick
);

    // ------------------------------------------------------------------------
    // accumulator
    // ------------------------------------------------------------------------
    reg  [32:0] acc;       // fractional phase, in hertz-cycles
    wire [32:0] sum;       // next phase before wrap

    assign sum = acc + {1'b0, rate_hz};

    // rates above the clock saturate to one tick per cycle; the stream
    // cannot move faster than the sample clock
    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            acc  <= 33'h000000000;
            tick <= 1'b0;
        end
        else if (clk_en)
        begin
            if (!run)
            begin
                // restart phase so the first interval is a whole one
                acc  <= 33'h000000000;
                tick <= 1'b0;
            end
            else if (sum >= {1'b0, `PQSS_CLK_HZ})
            begin
                acc  <= (sum - {1'b0, `PQSS_CLK_HZ} >= {1'b0, `PQSS_CLK_HZ}) ?
                        33'h000000000 : sum - {1'b0, `PQSS_CLK_HZ};
                tick <= 1'b1;
            end
            else
            begin
                acc  <= sum;
                tick <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

/* File: rtl/pqss_fifo.v */
// symbol fifo between the sequencer and the carrier-cycle apply stage
`timescale 1ns/1ps
`default_nettype none

module pqss_fifo
#(
    parameter WIDTH = 32,
    parameter DEPTH = 8,
    parameter AW    = 3
)
(
    input  wire             clock,
    input  wire             arst_n,
    input  wire             clk_en,
    input  wire             flush,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);

    // ------------------------------------------------------------------------
    // storage and pointers
    // ------------------------------------------------------------------------
    reg [WIDTH-1:0] mem [0:DEPTH-1];  // flip-flop storage
    reg [AW-1:0]    wr_ptr;           // next slot to fill
    reg [AW-1:0]    rd_ptr;           // oldest slot
    reg [AW:0]      count;            // occupancy
    wire            push;
    wire            pop;

    assign in_ready  = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_data  = mem[rd_ptr];

    // pointers wrap by depth so a non-power-of-two depth still works
    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end
        else if (clk_en)
        begin
            if (flush)
            begin
                wr_ptr <= {AW{1'b0}};
                rd_ptr <= {AW{1'b0}};
                count  <= {(AW+1){1'b0}};
            end
            else
            begin
                if (push)
                    wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
                if (pop)
                    rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
                if (push && !pop)
                    count <= count + 1'b1;
                else if (pop && !push)
                    count <= count - 1'b1;
            end
        end
    end

    // data storage carries no reset; only the pointers and count must be defined
    always @(posedge clock)
    begin
        if (clk_en && push && !flush)
            mem[wr_ptr] <= in_data;
    end

endmodule
`default_nettype wire

/* File: rtl/pqss_sequencer.v */
// symbol sequencer for phase-key and quadrature-amplitude modulation
`timescale 1ns/1ps
`default_nettype none
`include "pqss_consts.vh"

module pqss_sequencer
#(
    parameter DATA_DEPTH = 1024,   // data table size in bits
    parameter DATA_AW    = 10,
    parameter USER_DEPTH = 16,     // user table entries
    parameter USER_AW    = 4,
    parameter FIFO_DEPTH = 8
)
(
    input  wire               clock,
    input  wire               arst_n,
    input  wire               clk_en,
    input  wire               run,
    input  wire               qam_select,
    input  wire [2:0]         psk_type,
    input  wire               qam_type_wr,
    input  wire [1:0]         qam_type_value,
    output reg  [1:0]         qam_type,
    input  wire [3:0]         user_bits,
    input  wire [31:0]        baud_hz,
    input  wire [31:0]        basic_rate_hz,
    input  wire               marker_wr,
    input  wire [13:0]        marker_value,
    output reg  [13:0]        marker_index,
    input  wire               carrier_gate_wr,
    input  wire               carrier_gate_value,
    output reg                phase_key_carrier_gate,
    input  wire               data_clear,
    input  wire               data_wr,
    input  wire [7:0]         data_char,
    output reg  [DATA_AW:0]   data_len,
    output reg                data_bad_char,
    input  wire               user_clear,
    input  wire               user_wr,
    input  wire [15:0]        user_value,
    output reg  [USER_AW:0]   user_len,
    output reg                user_bad_value,
    input  wire               carrier_cycle_end,
    output reg                sym_valid,
    output reg  [7:0]         sym_code,
    output reg  [1:0]         sym_quadrant,
    output reg  [5:0]         sym_position,
    output reg  [15:0]        sym_user_value,
    output reg                sym_carrier_on,
    output reg                marker_pulse,
    output wire               stall
);

    // ------------------------------------------------------------------------
    // states and local sizes
    // ------------------------------------------------------------------------
    localparam [2:0] S_IDLE = 3'b001;   // waiting for run and a usable table
    localparam [2:0] S_RUN  = 3'b010;   // stepping on baud ticks
    localparam [2:0] S_WAIT = 3'b100;   // tick pending, fifo full
    localparam       FW     = 34;       // fifo word width

    reg  [2:0]            state;         // sequencer state
    reg  [2:0]            next_state;
    reg  [DATA_DEPTH-1:0] data_bits;     // loaded data table bits
    reg  [15:0]           user_tab [0:USER_DEPTH-1];
    reg  [DATA_AW:0]      rd_ptr;        // first bit of next symbol
    reg  [13:0]           sym_count;     // 1-based symbol number
    reg  [13:0]           active_marker; // marker fixed at table load
    reg  [3:0]            nbits;         // bits per symbol for mode
    reg  [7:0]            code;          // assembled symbol
    reg  [1:0]            quad;
    reg  [5:0]            pos;
    reg  [15:0]           uval;
    reg                   is_user;
    reg                   is_std_qam;
    wire [7:0]            window;        // eight bits from rd_ptr
    wire                  basic_mode;
    wire                  tick;
    wire                  fifo_in_ready;
    wire                  fifo_out_valid;
    wire [FW-1:0]         fifo_out;
    wire                  emit;
    wire                  table_ok;
    wire [DATA_AW:0]      next_ptr;
    integer               k;

    // ------------------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------------------
    assign basic_mode = !qam_select && (psk_type == `PQSS_PSK_BASIC);

    // symbol width follows the selected type
    always @*
    begin
        nbits      = 4'h1;
        is_user    = 1'b0;
        is_std_qam = 1'b0;
        if (qam_select)
        begin
            case (qam_type)
                `PQSS_QAM_16:   begin nbits = `PQSS_QAM16_BITS;  is_std_qam = 1'b1; end
                `PQSS_QAM_64:   begin nbits = `PQSS_QAM64_BITS;  is_std_qam = 1'b1; end
                `PQSS_QAM_256:  begin nbits = `PQSS_QAM256_BITS; is_std_qam = 1'b1; end
                default:        begin nbits = user_bits;         is_user = 1'b1;    end
            endcase
        end
        else
        begin
            case (psk_type)
                `PQSS_PSK_BASIC,
                `PQSS_PSK_BPSK:  nbits = 4'h1;
                `PQSS_PSK_QPSK,
                `PQSS_PSK_OQPSK,
                `PQSS_PSK_DQPSK: nbits = 4'h2;
                `PQSS_PSK_8:     nbits = 4'h3;
                `PQSS_PSK_16:    nbits = 4'h4;
                default:         begin nbits = user_bits; is_user = 1'b1; end
            endcase
        end
        // guard against a zero or oversize user width
        if (nbits == 4'h0)
            nbits = 4'h1;
        else if (nbits > 4'h8)
            nbits = 4'h8;
    end

    // ------------------------------------------------------------------------
    // configuration registers with readback
    // ------------------------------------------------------------------------
    // out-of-range marker writes are dropped, the old value stays; type writes always store
    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            marker_index           <= `PQSS_MARKER_DEFAULT;
            phase_key_carrier_gate <= `PQSS_CARRIER_DEFAULT;
            qam_type               <= `PQSS_QAM_DEFAULT;
        end
        else if (clk_en)
        begin
            if (marker_wr && marker_value >= `PQSS_MARKER_MIN && marker_value <= `PQSS_MARKER_MAX)
                marker_index <= marker_value;
            if (carrier_gate_wr)
                phase_key_carrier_gate <= carrier_gate_value;
            if (qam_type_wr)
                qam_type <= qam_type_value;
        end
    end

    // ------------------------------------------------------------------------
    // data table loading
    // ------------------------------------------------------------------------
    // characters other than '0' and '1' are refused and flagged for a cycle
    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            data_len      <= {(DATA_AW+1){1'b0}};
            data_bad_char <= 1'b0;
            active_marker <= `PQSS_MARKER_DEFAULT;
        end
        else if (clk_en)
        begin
            data_bad_char <= 1'b0;
            if (data_clear)
            begin
                data_len      <= {(DATA_AW+1){1'b0}};
                active_marker <= marker_index;
            end
            else if (data_wr)
            begin
                if ((data_char == `PQSS_CHAR_ZERO || data_char == `PQSS_CHAR_ONE) &&
                    data_len != DATA_DEPTH[DATA_AW:0])
                    data_len <= data_len + 1'b1;
                else
                    data_bad_char <= 1'b1;
            end
        end
    end

    // bit storage, no reset needed: data_len bounds what is read
    always @(posedge clock)
    begin
        if (clk_en && data_wr && !data_clear && data_len != DATA_DEPTH[DATA_AW:0] &&
            (data_char == `PQSS_CHAR_ZERO || data_char == `PQSS_CHAR_ONE))
            data_bits[data_len[DATA_AW-1:0]] <= (data_char == `PQSS_CHAR_ONE);
    end

    // ------------------------------------------------------------------------
    // user symbol table loading
    // ------------------------------------------------------------------------
    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            user_len       <= {(USER_AW+1){1'b0}};
            user_bad_value <= 1'b0;
        end
        else if (clk_en)
        begin
            user_bad_value <= 1'b0;
            if (user_clear)
                user_len <= {(USER_AW+1){1'b0}};
            else if (user_wr)
            begin
                if (user_value <= `PQSS_USER_PHASE_MAX && user_len != USER_DEPTH[USER_AW:0])
                    user_len <= user_len + 1'b1;
                else
                    user_bad_value <= 1'b1;
            end
        end
    end

    always @(posedge clock)
    begin
        if (clk_en && user_wr && !user_clear && user_value <= `PQSS_USER_PHASE_MAX &&
            user_len != USER_DEPTH[USER_AW:0])
            user_tab[user_len[USER_AW-1:0]] <= user_value;
    end

    // ------------------------------------------------------------------------
    // symbol assembly
    // ------------------------------------------------------------------------
    // eight-bit read window; bits past the table end read as zero
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1)
        begin : g_win
            localparam [DATA_AW:0] OFS = g;   // offset of this window bit
            wire [DATA_AW:0] idx = rd_ptr + OFS;
            assign window[g] = (idx < DATA_DEPTH[DATA_AW:0]) ? data_bits[idx[DATA_AW-1:0]] : 1'b0;
        end
    endgenerate

    // the first bit on the stream is the most significant of the symbol
    always @*
    begin
        code = 8'h00;
        for (k = 0; k < 8; k = k + 1)
        begin
            if (k < nbits)
                code[nbits - 1 - k] = window[k];
        end
        quad = 2'h0;
        pos  = code[5:0];
        if (is_std_qam)
        begin
            quad = code[nbits - 1 -: 2];
            pos  = code[5:0] & ((6'h01 << (nbits - 4'h2)) - 6'h01);
        end
        uval = is_user ? user_tab[code[USER_AW-1:0]] : 16'h0000;
    end

    // ------------------------------------------------------------------------
    // stepping control
    // ------------------------------------------------------------------------
    // a trailing partial symbol is never played; the table must hold one
    assign table_ok = (data_len >= {{(DATA_AW-3){1'b0}}, nbits});
    assign emit     = ((state == S_RUN && tick) || state == S_WAIT) && fifo_in_ready;
    // wrap to first entry
    // wrap when the symbol after this one would run past the loaded length
    assign next_ptr = (rd_ptr + {{(DATA_AW-4){1'b0}}, nbits, 1'b0} > data_len) ?
                      {(DATA_AW+1){1'b0}} : rd_ptr + {{(DATA_AW-3){1'b0}}, nbits};
    assign stall    = (state == S_WAIT);

    pqss_baud_gen u_baud
    (
        .clock   (clock),
        .arst_n  (arst_n),
        .clk_en  (clk_en),
        .run     (run && table_ok && state != S_IDLE),
        .rate_hz (basic_mode ? basic_rate_hz : baud_hz),
        .tick    (tick)
    );

    // state transitions
    always @*
    begin
        next_state = state;
        case (state)
            S_IDLE:  if (run && table_ok) next_state = S_RUN;
            S_RUN:   if (!run || !table_ok) next_state = S_IDLE;
                     else if (tick && !fifo_in_ready) next_state = S_WAIT;
            S_WAIT:  if (!run || !table_ok) next_state = S_IDLE;
                     else if (fifo_in_ready) next_state = S_RUN;
            default: next_state = S_IDLE;
        endcase
    end

    // pointer and symbol counter advance once per emitted symbol
    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state     <= S_IDLE;
            rd_ptr    <= {(DATA_AW+1){1'b0}};
            sym_count <= 14'h0001;
        end
        else if (clk_en)
        begin
            state <= next_state;
            if (next_state == S_IDLE)
            begin
                rd_ptr    <= {(DATA_AW+1){1'b0}};
                sym_count <= 14'h0001;
            end
            else if (emit)
            begin
                rd_ptr    <= next_ptr;
                sym_count <= (next_ptr == {(DATA_AW+1){1'b0}}) ? 14'h0001 : sym_count + 14'h0001;
            end
        end
    end

    // ------------------------------------------------------------------------
    // fifo toward the carrier-cycle apply stage
    // ------------------------------------------------------------------------
    pqss_fifo
    #(
        .WIDTH (FW),
        .DEPTH (FIFO_DEPTH),
        .AW    (3)
    )
    u_fifo
    (
        .clock     (clock),
        .arst_n    (arst_n),
        .clk_en    (clk_en),
        .flush     (state == S_IDLE),
        .in_valid  (emit),
        .in_ready  (fifo_in_ready),
        .in_data   ({(sym_count == active_marker),
                     // gate off drops carrier; not in basic mode
                     (phase_key_carrier_gate | basic_mode),
                     uval, pos, quad, code}),
        .out_valid (fifo_out_valid),
        .out_ready (carrier_cycle_end),
        .out_data  (fifo_out)
    );

    // ------------------------------------------------------------------------
    // applied symbol
    // ------------------------------------------------------------------------
    // symbol fields load only at cycle end; sym_valid clears in idle
    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sym_valid      <= 1'b0;
            sym_code       <= 8'h00;
            sym_quadrant   <= 2'h0;
            sym_position   <= 6'h00;
            sym_user_value <= 16'h0000;
            sym_carrier_on <= `PQSS_CARRIER_DEFAULT;
            marker_pulse   <= 1'b0;
        end
        else if (clk_en)
        begin
            marker_pulse <= 1'b0;
            if (carrier_cycle_end && fifo_out_valid)
            begin
                sym_valid      <= 1'b1;
                sym_code       <= fifo_out[7:0];
                sym_quadrant   <= fifo_out[9:8];
                sym_position   <= fifo_out[15:10];
                sym_user_value <= fifo_out[31:16];
                sym_carrier_on <= fifo_out[32];
                marker_pulse   <= fifo_out[33];
            end
            else if (state == S_IDLE)
                sym_valid <= 1'b0;
        end
    end

endmodule
`default_nettype wire

/* File: verif/pqss_sva.sv */
// checker: port-level assertions for the symbol sequencer
`timescale 1ns/1ps
`default_nettype none
module pqss_sva
(
    input wire logic        clock,
    input wire logic        arst_n,
    input wire logic        qam_select,
    input wire logic [2:0]  psk_type,
    input wire logic        qam_type_wr,
    input wire logic [1:0]  qam_type_value,
    input wire logic [1:0]  qam_type,
    input wire logic        marker_wr,
    input wire logic [13:0] marker_value,
    input wire logic [13:0] marker_index,
    input wire logic        carrier_gate_wr,
    input wire logic        carrier_gate_value,
    input wire logic        phase_key_carrier_gate,
    input wire logic        carrier_cycle_end,
    input wire logic        sym_valid,
    input wire logic [7:0]  sym_code,
    input wire logic [1:0]  sym_quadrant,
    input wire logic [5:0]  sym_position,
    input wire logic        sym_carrier_on,
    input wire logic        marker_pulse
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    a_marker_range: assert property (marker_index inside {[14'h0001:14'h2710]})
        else $error("marker index out of range");
    a_marker_drop: assert property (marker_wr && !(marker_value inside {[14'h0001:14'h2710]}) |=> $stable(marker_index))
        else $error("bad marker write stored");
    a_marker_take: assert property (marker_wr && marker_value inside {[14'h0001:14'h2710]} |=> marker_index == $past(marker_value))
        else $error("marker readback wrong");
    a_gate_take: assert property (carrier_gate_wr |=> phase_key_carrier_gate == $past(carrier_gate_value))
        else $error("carrier gate readback wrong");
    a_type_take: assert property (qam_type_wr |=> qam_type == $past(qam_type_value))
        else $error("amplitude type readback wrong");
    a_apply_cause: assert property ($rose(sym_valid) |-> $past(carrier_cycle_end))
        else $error("symbol applied without cycle end");
    a_quad_split: assert property (sym_valid && qam_select && qam_type == 2'h0 |-> sym_quadrant == sym_code[3:2] && sym_position == {4'h0, sym_code[1:0]})
        else $error("quadrant or position wrong");
    a_basic_carrier: assert property (sym_valid && !qam_select && psk_type == 3'h0 |-> sym_carrier_on)
        else $error("basic type obeyed carrier gate");
    a_marker_cause: assert property (marker_pulse |-> $past(carrier_cycle_end) && sym_valid)
        else $error("marker pulse without applied symbol");
endmodule
bind pqss_sequencer pqss_sva i_sva (.*);
`default_nettype wire

/* File: verif/pqss_synth_model.sv */
// synthesis-stage model: ends a carrier cycle every period+1 clocks
`timescale 1ns/1ps
`default_nettype none
module pqss_synth_model
(
    input  wire logic       clock,
    input  wire logic       arst_n,
    input  wire logic       enable,
    input  wire logic [7:0] period,
    output wire logic       carrier_cycle_end
);
    logic [7:0] count; // clocks into the running carrier cycle
    always @(posedge clock or negedge arst_n)
        if (!arst_n)
            count <= 8'h00;
        else
            count <= (enable && count < period) ? count + 8'h01 : 8'h00;
    assign carrier_cycle_end = enable && count == period;
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
// testbench: config writes, table loads and applied-symbol checks
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clock, arst_n, clk_en, run, qam_select, qam_type_wr, marker_wr, carrier_gate_wr, carrier_gate_value;
    logic data_clear, data_wr, data_bad_char, user_clear, user_wr, user_bad_value, carrier_cycle_end;
    logic sym_valid, sym_carrier_on, marker_pulse, stall, enable, phase_key_carrier_gate;
    logic [1:0] qam_type_value, qam_type, sym_quadrant;
    logic [2:0] psk_type;
    logic [3:0] user_bits;
    logic [4:0] user_len;
    logic [5:0] sym_position;
    logic [7:0] data_char, sym_code, period;
    logic [10:0] data_len;
    logic [13:0] marker_value, marker_index;
    logic [15:0] user_value, sym_user_value;
    logic [31:0] baud_hz, basic_rate_hz;
    int n_fail, checks_done, i, k;
    pqss_sequencer i_dut (.*);
    pqss_synth_model i_synth (.*);
    initial begin clock = 0; forever #2.5 clock = ~clock; end
    task chk(input logic [15:0] g, e);
        checks_done++;
        if (g !== e) begin n_fail++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end
    endtask
    task automatic wr(ref logic s);
        s = 1; @(posedge clock) #1 s = 0; @(posedge clock) #1;
    endtask
    // walk the table characters with the strobe held high
    task load(input string s);
        data_clear = 1; @(posedge clock) #1 data_clear = 0; data_wr = 1;
        for (k = 0; k < s.len(); k++) begin data_char = s[k]; @(posedge clock) #1; end
        data_wr = 0;
    endtask
    // wait for one applied symbol, bounded
    task nxt;
        for (i = 0; i < 99 && carrier_cycle_end !== 1'b1; i++) @(posedge clock) #1;
        @(posedge clock) #1;
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin #20000; n_fail++; close_out; end
    initial begin
        {arst_n, run, qam_select, qam_type_wr, marker_wr, carrier_gate_wr, carrier_gate_value} = 0;
        {data_clear, data_wr, user_clear, user_wr, psk_type, qam_type_value, marker_value} = 0;
        {data_char, user_value, enable} = 0;
        clk_en = 1; user_bits = 4'h4; period = 8'h0C; baud_hz = 32'h02FAF080; basic_rate_hz = 32'h0BEBC200;
        repeat (3) @(posedge clock);
        #1 arst_n = 1;
        chk(marker_index, 16'h0001);
        chk(phase_key_carrier_gate, 16'h0001);
        chk(qam_type, 16'h0000);
        marker_value = 14'h0003; wr(marker_wr); chk(marker_index, 16'h0003);
        marker_value = 14'h2711; wr(marker_wr); chk(marker_index, 16'h0003);
        for (k = 3; k >= 0; k--) begin qam_type_value = k; wr(qam_type_wr); chk(qam_type, k); end
        marker_value = 14'h0002; wr(marker_wr); load("01001111");
        @(posedge clock) #1 data_char = 8'h78; data_wr = 1;
        @(posedge clock) #1 data_wr = 0; chk(data_bad_char, 16'h0001);
        chk(data_len, 16'h0008);
        qam_select = 1; run = 1; enable = 1;
        for (k = 0; k < 4; k++) begin nxt; chk(sym_code, k[0] ? 16'h000F : 16'h0004); chk(marker_pulse, k[0]); end
        chk(stall, 16'h0001);
        run = 0; enable = 0; carrier_gate_value = 0; wr(carrier_gate_wr); chk(phase_key_carrier_gate, 16'h0000);
        wr(user_clear); user_value = 16'h0064; wr(user_wr); user_value = 16'h00C8; wr(user_wr);
        user_value = 16'h8CA1; user_wr = 1; @(posedge clock) #1 user_wr = 0; chk(user_bad_value, 16'h0001);
        chk(user_len, 16'h0002);
        load("00000001"); qam_type_value = 2'h3; wr(qam_type_wr); run = 1; enable = 1;
        nxt; chk(sym_user_value, 16'h0064); chk(sym_carrier_on, 16'h0000);
        nxt; chk(sym_user_value, 16'h00C8);
        run = 0; enable = 0; repeat (2) @(posedge clock);
        #1 qam_select = 0; period = 8'h03; run = 1; enable = 1;
        nxt; chk(sym_carrier_on, 16'h0001); chk(sym_code, 16'h0000);
        close_out;
    end
endmodule
`default_nettype wire
